// *** rtl/dcd_pkg.sv ***
package dcd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W      = 8;
  localparam logic [7:0]  OFS_INSTR  = 8'h00;
  localparam logic [7:0]  OFS_XFER   = 8'h04;
  localparam logic [7:0]  OFS_IMM    = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0C;
  localparam logic [7:0]  OFS_LOOP   = 8'h10;
  localparam logic [7:0]  OFS_PC     = 8'h14;
  localparam logic [7:0]  OFS_GO     = 8'h18;
  localparam logic [7:0]  OFS_RESULT = 8'h1C;
  localparam logic [7:0]  OFS_DMADDR = 8'h20;
  localparam logic [7:0]  OFS_PMADDR = 8'h24;
  localparam logic [7:0]  OFS_TARGET = 8'h28;
  localparam logic [7:0]  OFS_IMMVAL = 8'h2C;
  // address bits [7:6] select the index or modify register windows
  localparam logic [1:0]  WIN_INDEX  = 2'h1;
  localparam logic [1:0]  WIN_MODIFY = 2'h2;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [31:0] LCE_COUNT  = 32'h0000_0000;
  localparam logic [1:0]  DB_SLOTS   = 2'h2;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    COND_EQ  = 5'h00, COND_NE  = 5'h01, COND_LT  = 5'h02, COND_GE  = 5'h03,
    COND_LE  = 5'h04, COND_GT  = 5'h05, COND_AC  = 5'h06, COND_NAC = 5'h07,
    COND_AV  = 5'h08, COND_NAV = 5'h09, COND_MV  = 5'h0A, COND_NMV = 5'h0B,
    COND_MS  = 5'h0C, COND_NMS = 5'h0D, COND_SV  = 5'h0E, COND_NSV = 5'h0F,
    COND_SZ  = 5'h10, COND_NSZ = 5'h11, COND_F0  = 5'h12, COND_NF0 = 5'h13,
    COND_F1  = 5'h14, COND_NF1 = 5'h15, COND_F2  = 5'h16, COND_NF2 = 5'h17,
    COND_F3  = 5'h18, COND_NF3 = 5'h19, COND_TF  = 5'h1A, COND_NTF = 5'h1B,
    COND_LCE = 5'h1C, COND_NLCE = 5'h1D, COND_FOREVER = 5'h1E,
    COND_TRUE = 5'h1F
  } dcd_cond_type;

  typedef enum logic [1:0] {
    IMM_W6 = 2'h0, IMM_W16 = 2'h1, IMM_W24 = 2'h2, IMM_W32 = 2'h3
  } dcd_imm_width_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_CALC = 2'b10, ST_WBPM = 2'b11
  } dcd_state_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              pm_direct;
    logic              dm_direct;
    logic              loop_abort_option;
    logic              delayed_branch_option;
    logic              relative;
    logic              branch;
    logic              imm_sgn;
    dcd_imm_width_type imm_w;
    logic              term;
    dcd_cond_type      cond;
  } dcd_instr_type;

  typedef struct packed {
    logic       pm_pre;
    logic       dm_pre;
    logic       pm_wr;
    logic       dm_wr;
    logic       pm_imm;
    logic       dm_imm;
    logic       pm_en;
    logic       dm_en;
    logic [5:0] data6;
    logic [2:0] pm_modify_select;
    logic [2:0] pm_index_select;
    logic [2:0] dm_modify_select;
    logic [2:0] dm_index_select;
  } dcd_xfer_type;

  typedef struct packed {
    logic bit_test_flag;
    logic sz;
    logic sv;
    logic ms;
    logic mv;
    logic av;
    logic ac;
    logic an;
    logic az;
  } dcd_status_type;

  typedef struct packed {
    logic        dm_go;
    logic        dm_wr;
    logic [31:0] dm_addr;
    logic        pm_go;
    logic        pm_wr;
    logic [23:0] pm_addr;
  } dcd_xfer_out_type;

  typedef struct packed {
    logic        take;
    logic        pop_loop;
    logic        pop_pc;
    logic [23:0] target;
  } dcd_seq_out_type;

endpackage

// *** rtl/dcd_regfile.sv ***
`timescale 1ns/10ps
module dcd_regfile #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          rst_b_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // two registered read ports
  input  wire logic [AW-1:0] raddr_a_i,
  input  wire logic [AW-1:0] raddr_b_i,
  output logic      [W-1:0]  rdata_a_o,
  output logic      [W-1:0]  rdata_b_o
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // a read in the cycle of a write to the same entry returns old data
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end

endmodule

// *** rtl/dcd_decode.sv ***
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module dcd_decode #(
  parameter int unsigned AGEN_DEPTH = 16
) (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_b_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // external flag inputs
  input  wire logic [3:0]              flag_in_i,
  // transfer requests and sequencer commands
  output dcd_pkg::dcd_xfer_out_type    xfer_o,
  output dcd_pkg::dcd_seq_out_type     seq_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // odd codes are the complement of the even code below them
  function automatic logic cond_eval(input logic [4:0]              c,
                                     input dcd_pkg::dcd_status_type s,
                                     input logic [3:0]              f,
                                     input logic                    lce);
    logic b;
    b = 1'b0;
    case (c[4:1])
      4'h0: b = s.az;
      4'h1: b = s.an;
      4'h2: b = s.az | s.an;
      4'h3: b = s.ac;
      4'h4: b = s.av;
      4'h5: b = s.mv;
      4'h6: b = s.ms;
      4'h7: b = s.sv;
      4'h8: b = s.sz;
      4'h9: b = f[0];
      4'hA: b = f[1];
      4'hB: b = f[2];
      4'hC: b = f[3];
      4'hD: b = s.bit_test_flag;
      4'hE: b = lce;
      default: b = 1'b0;
    endcase
    return b ^ c[0];
  endfunction

  function automatic logic [31:0] imm_ext(input logic [31:0] v,
                                          input logic [1:0]  w,
                                          input logic        sgn);
    logic [31:0] r;
    r = v;
    case (w)
      dcd_pkg::IMM_W6:  r = {{26{sgn & v[5]}}, v[5:0]};
      dcd_pkg::IMM_W16: r = {{16{sgn & v[15]}}, v[15:0]};
      dcd_pkg::IMM_W24: r = {{8{sgn & v[23]}}, v[23:0]};
      default:          r = v;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcd_pkg::dcd_instr_type  instr_reg;
  dcd_pkg::dcd_xfer_type   xfer_reg;
  dcd_pkg::dcd_status_type status_reg;
  dcd_pkg::dcd_state_type  state_reg;
  dcd_pkg::dcd_state_type  state_next;
  logic [31:0]             imm_reg;
  logic [31:0]             loop_reg;
  logic [23:0]             pc_reg;
  logic                    res_exec_reg;
  logic                    res_cond_reg;
  logic [1:0]              pend_reg;
  logic [23:0]             tgt_reg;
  logic                    abort_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        req       = wb_cyc_i & wb_stb_i;
  wire        wr_commit = req & wb_we_i & wb_ack_o;
  wire [7:0]  word_adr  = {wb_adr_i[7:2], 2'b00};
  wire        in_index  = wb_adr_i[7:6] == dcd_pkg::WIN_INDEX;
  wire        in_modify = wb_adr_i[7:6] == dcd_pkg::WIN_MODIFY;
  wire        idle      = state_reg == dcd_pkg::ST_IDLE;
  wire        go_wr     = wr_commit & (word_adr == dcd_pkg::OFS_GO);
  wire [31:0] result_w  = {27'h0, pend_reg, ~idle, res_cond_reg,
                           res_exec_reg};
  wire [31:0] imm_val;

  wire [31:0] rd_word =
    (word_adr == dcd_pkg::OFS_INSTR)  ? {17'h0, instr_reg} :
    (word_adr == dcd_pkg::OFS_XFER)   ? {6'h0, xfer_reg} :
    (word_adr == dcd_pkg::OFS_IMM)    ? imm_reg :
    (word_adr == dcd_pkg::OFS_STATUS) ? {23'h0, status_reg} :
    (word_adr == dcd_pkg::OFS_LOOP)   ? loop_reg :
    (word_adr == dcd_pkg::OFS_PC)     ? {8'h0, pc_reg} :
    (word_adr == dcd_pkg::OFS_RESULT) ? result_w :
    (word_adr == dcd_pkg::OFS_DMADDR) ? xfer_o.dm_addr :
    (word_adr == dcd_pkg::OFS_PMADDR) ? {8'h0, xfer_o.pm_addr} :
    (word_adr == dcd_pkg::OFS_TARGET) ? {8'h0, seq_o.target} :
    (word_adr == dcd_pkg::OFS_IMMVAL) ? imm_val : 32'h0000_0000;
  wire [31:0] wr_word = merge(rd_word, wb_dat_i, wb_sel_i);

  // ----------------------------------------------------------------
  // address generator register files
  // ----------------------------------------------------------------
  logic [31:0] idx_a;
  logic [31:0] idx_b;
  logic [31:0] mod_a;
  logic [31:0] mod_b;
  logic        idx_we;
  logic [3:0]  idx_waddr;
  logic [31:0] idx_wdata;
  wire  [31:0] d6_ext = {{26{xfer_reg.data6[5]}}, xfer_reg.data6};
  wire  [31:0] dm_mod = xfer_reg.dm_imm ? d6_ext : mod_a;
  wire  [31:0] pm_mod = xfer_reg.pm_imm ? d6_ext : mod_b;
  wire  [31:0] dm_sum = idx_a + dm_mod;
  wire  [31:0] pm_sum = idx_b + pm_mod;
  wire  [31:0] pm_eff = xfer_reg.pm_pre ? pm_sum : idx_b;
  wire  [31:0] dm_addr = instr_reg.dm_direct ? imm_reg :
                         xfer_reg.dm_pre ? dm_sum : idx_a;
  wire  [23:0] pm_addr = instr_reg.pm_direct ? imm_reg[23:0] :
                         pm_eff[23:0];

  // first generator owns entries 0..7, second owns 8..15
  wire  [3:0]  dm_idx_sel = {1'b0, xfer_reg.dm_index_select};
  wire  [3:0]  dm_mod_sel = {1'b0, xfer_reg.dm_modify_select};
  wire  [3:0]  pm_idx_sel = {1'b1, xfer_reg.pm_index_select};
  wire  [3:0]  pm_mod_sel = {1'b1, xfer_reg.pm_modify_select};

  dcd_regfile #(.W(32), .DEPTH(AGEN_DEPTH)) u_index (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .we_i      (idx_we),
    .waddr_i   (idx_waddr),
    .wdata_i   (idx_wdata),
    .raddr_a_i (dm_idx_sel),
    .raddr_b_i (pm_idx_sel),
    .rdata_a_o (idx_a),
    .rdata_b_o (idx_b)
  );

  dcd_regfile #(.W(32), .DEPTH(AGEN_DEPTH)) u_modify (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .we_i      (wr_commit & in_modify),
    .waddr_i   (wb_adr_i[5:2]),
    .wdata_i   (wb_dat_i),
    .raddr_a_i (dm_mod_sel),
    .raddr_b_i (pm_mod_sel),
    .rdata_a_o (mod_a),
    .rdata_b_o (mod_b)
  );

  // ----------------------------------------------------------------
  // condition, immediate and branch decode
  // ----------------------------------------------------------------
  wire        calc     = state_reg == dcd_pkg::ST_CALC;
  wire        wbpm     = state_reg == dcd_pkg::ST_WBPM;
  wire        lce      = loop_reg == dcd_pkg::LCE_COUNT;
  wire        cond_now = cond_eval(instr_reg.cond, status_reg,
                                   flag_in_i, lce);
  // a termination form is a loop setup: it always runs
  wire        exec     = instr_reg.term | cond_now;
  assign      imm_val  = imm_ext(imm_reg, instr_reg.imm_w,
                                 instr_reg.imm_sgn);
  wire [23:0] rel_tgt  = pc_reg + imm_val[23:0];
  wire [23:0] new_tgt  = instr_reg.relative ? rel_tgt : imm_reg[23:0];
  // a branch sitting in a delay slot is not taken
  wire        br_ok    = exec & instr_reg.branch & (pend_reg == 2'h0);
  wire        br_db    = br_ok & instr_reg.delayed_branch_option;
  wire        take_now = calc & ((br_ok & ~br_db) |
                                 (pend_reg == 2'h1));
  wire        dm_upd   = exec & xfer_reg.dm_en & ~xfer_reg.dm_pre &
                         ~instr_reg.dm_direct;
  wire        pm_upd   = res_exec_reg & xfer_reg.pm_en &
                         ~xfer_reg.pm_pre & ~instr_reg.pm_direct;

  // two index updates share one write port, so they go in turn
  assign idx_we    = (wr_commit & in_index) | (calc & dm_upd) |
                     (wbpm & pm_upd);
  assign idx_waddr = calc ? dm_idx_sel : wbpm ? pm_idx_sel :
                     wb_adr_i[5:2];
  assign idx_wdata = calc ? dm_sum : wbpm ? pm_sum : wb_dat_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dcd_pkg::ST_IDLE: if (go_wr) state_next = dcd_pkg::ST_WAIT;
      dcd_pkg::ST_WAIT: state_next = dcd_pkg::ST_CALC;
      dcd_pkg::ST_CALC: state_next = dcd_pkg::ST_WBPM;
      default:          state_next = dcd_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave and software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= dcd_pkg::RST_WORD;
    end else begin
      wb_ack_o <= req & ~wb_ack_o & idle;
      wb_dat_o <= rd_word;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_reg  <= '0;
      xfer_reg   <= '0;
      status_reg <= '0;
      imm_reg    <= dcd_pkg::RST_WORD;
      loop_reg   <= dcd_pkg::RST_WORD;
      pc_reg     <= '0;
    end else if (wr_commit) begin
      if (word_adr == dcd_pkg::OFS_INSTR) begin
        instr_reg <= dcd_pkg::dcd_instr_type'(wr_word[14:0]);
      end else if (word_adr == dcd_pkg::OFS_XFER) begin
        xfer_reg <= dcd_pkg::dcd_xfer_type'(wr_word[25:0]);
      end else if (word_adr == dcd_pkg::OFS_IMM) begin
        imm_reg <= wr_word;
      end else if (word_adr == dcd_pkg::OFS_STATUS) begin
        status_reg <= dcd_pkg::dcd_status_type'(wr_word[8:0]);
      end else if (word_adr == dcd_pkg::OFS_LOOP) begin
        loop_reg <= wr_word;
      end else if (word_adr == dcd_pkg::OFS_PC) begin
        pc_reg <= wr_word[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // decode sequence and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= dcd_pkg::ST_IDLE;
      res_exec_reg <= 1'b0;
      res_cond_reg <= 1'b0;
      xfer_o       <= '0;
    end else begin
      state_reg    <= state_next;
      xfer_o.dm_go <= calc & exec & xfer_reg.dm_en;
      xfer_o.pm_go <= calc & exec & xfer_reg.pm_en;
      if (calc) begin
        res_exec_reg   <= exec;
        res_cond_reg   <= cond_now;
        xfer_o.dm_wr   <= xfer_reg.dm_wr;
        xfer_o.dm_addr <= dm_addr;
        xfer_o.pm_wr   <= xfer_reg.pm_wr;
        xfer_o.pm_addr <= pm_addr;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg  <= 2'h0;
      tgt_reg   <= '0;
      abort_reg <= 1'b0;
      seq_o     <= '0;
    end else begin
      seq_o.take     <= take_now;
      seq_o.pop_loop <= take_now & (br_db | pend_reg != 2'h0 ? abort_reg
                        : instr_reg.loop_abort_option);
      seq_o.pop_pc   <= take_now & (br_db | pend_reg != 2'h0 ? abort_reg
                        : instr_reg.loop_abort_option);
      if (take_now) begin
        seq_o.target <= pend_reg != 2'h0 ? tgt_reg : new_tgt;
      end
      if (calc & br_db) begin
        pend_reg  <= dcd_pkg::DB_SLOTS;
        tgt_reg   <= new_tgt;
        abort_reg <= instr_reg.loop_abort_option;
      end else if (calc & pend_reg != 2'h0) begin
        pend_reg  <= pend_reg - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_suppress_xfer: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && !exec |=> !xfer_o.dm_go && !xfer_o.pm_go)
    else $error("suppressed instruction issued a transfer");

  a_eq_from_zero: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && instr_reg.cond == dcd_pkg::COND_EQ
    |=> res_cond_reg == $past(status_reg.az))
    else $error("eq does not follow ALU zero");

  a_gt_from_flags: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && instr_reg.cond == dcd_pkg::COND_GT
    |=> res_cond_reg == !($past(status_reg.az) || $past(status_reg.an)))
    else $error("gt does not follow ALU zero and sign");

  a_lce_expired: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && instr_reg.cond == dcd_pkg::COND_LCE
    |=> res_cond_reg == $past(lce))
    else $error("loop expired test wrong");

  a_nlce_running: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && instr_reg.cond == dcd_pkg::COND_NLCE
    && loop_reg != dcd_pkg::LCE_COUNT |=> res_cond_reg)
    else $error("not expired test false while counting");

  a_forever_true: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && (instr_reg.cond == dcd_pkg::COND_FOREVER
    || instr_reg.cond == dcd_pkg::COND_TRUE)
    |=> res_cond_reg == ($past(instr_reg.cond) == dcd_pkg::COND_TRUE))
    else $error("forever or true evaluated wrongly");

  a_dm_bank: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && idx_we |-> !idx_waddr[3])
    else $error("data update left the first generator");

  a_pm_bank: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) wbpm && idx_we |-> idx_waddr[3])
    else $error("program update left the second generator");

  a_delay_slots: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && br_db |=> !seq_o.take [*4]
    ##1 !seq_o.take)
    else $error("delayed branch taken too early");

  a_abort_pops: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) seq_o.pop_loop |-> seq_o.take && seq_o.pop_pc)
    else $error("loop abort without branch or PC pop");

  a_rel_target: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) calc && br_ok && !br_db && instr_reg.relative
    |=> seq_o.take && seq_o.target == $past(rel_tgt))
    else $error("relative target wrong");

endmodule

// *** verif/dcd_far_end.sv ***
`timescale 1ns/10ps
module dcd_far_end (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  // flag source and observed outputs
  input  wire logic [3:0]                flag_set_i,
  output logic      [3:0]                flag_o,
  input  wire dcd_pkg::dcd_xfer_out_type xfer_i,
  input  wire dcd_pkg::dcd_seq_out_type  seq_i,
  // pulse counts
  output int                             n_dm_o,
  output int                             n_pm_o,
  output int                             n_take_o,
  output int                             n_pop_o
);
  // flags change only on an edge, as a synchronous status source would
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o   <= 4'h0;
      n_dm_o   <= 0;
      n_pm_o   <= 0;
      n_take_o <= 0;
      n_pop_o  <= 0;
    end else begin
      flag_o   <= flag_set_i;
      n_dm_o   <= n_dm_o + int'(xfer_i.dm_go === 1'b1);
      n_pm_o   <= n_pm_o + int'(xfer_i.pm_go === 1'b1);
      n_take_o <= n_take_o + int'(seq_i.take === 1'b1);
      n_pop_o  <= n_pop_o + int'(seq_i.pop_loop === 1'b1) +
                  int'(seq_i.pop_pc === 1'b1);
    end
  end
endmodule

// *** verif/tb_dsp_condition_and_transfer_decode.sv ***
`timescale 1ns/10ps
module tb_dsp_condition_and_transfer_decode;
  logic clock_i, rst_b_i, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel, fl, fset;
  logic [31:0] wd, rd, q;
  dcd_pkg::dcd_xfer_out_type xo;
  dcd_pkg::dcd_seq_out_type so;
  int n_dm, n_pm, n_tk, n_pop, n_mismatch, cmp_count, nt;
  dcd_decode u_dcd_decode (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .flag_in_i(fl), .xfer_o(xo), .seq_o(so));
  dcd_far_end u_dcd_far_end (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .flag_set_i(fset), .flag_o(fl), .xfer_i(xo), .seq_i(so),
    .n_dm_o(n_dm), .n_pm_o(n_pm), .n_take_o(n_tk), .n_pop_o(n_pop));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // ------------------------------------------------------------
  // bus access and comparison
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    sel <= 4'hF;
    // the request stands until the edge at which ack is seen high;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clock_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  // a decode has finished once the result read after it is answered
  task automatic go();
    wb(1'b1, 8'h18, 32'h0000_0001);
    wb(1'b0, 8'h1C, 32'h0000_0000);
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic exp_c(int c, logic [8:0] s, logic [3:0] f,
                                 logic z);
    logic b;
    case (c >> 1)
      0:  b = s[0];
      1:  b = s[1];
      2:  b = s[0] | s[1];
      13: b = s[8];
      14: b = z;
      15: b = 1'b0;
      default: b = ((c >> 1) < 9) ? s[(c >> 1) - 1] : f[(c >> 1) - 9];
    endcase
    return b ^ c[0];
  endfunction
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [8:0] st;
    logic e;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wd = 32'h0000_0000;
    fset = 4'h0;
    rst_b_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    nt = 0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    wb(1'b1, 8'h04, 32'h000C_0000);
    for (int p = 0; p < 2; p++) begin
      st = p ? 9'h0AA : 9'h155;
      fset <= p ? 4'hA : 4'h5;
      wb(1'b1, 8'h0C, {23'h0, st});
      wb(1'b1, 8'h10, p ? 32'h0000_0005 : 32'h0000_0000);
      for (int c = 0; c < 32; c++) begin
        e = exp_c(c, st, p ? 4'hA : 4'h5, p == 0);
        nt += int'(e);
        wb(1'b1, 8'h00, c);
        go();
        chk("cond", {2{e}}, q[1:0]);
      end
    end
    chk("dm go count", nt, n_dm);
    chk("pm go count", nt, n_pm);
    $display("test conditions done");
    wb(1'b1, 8'h48, 32'h0000_0100);
    wb(1'b1, 8'h8C, 32'h0000_0004);
    wb(1'b1, 8'h64, 32'h0000_0200);
    wb(1'b1, 8'hA8, 32'h0000_0001);
    wb(1'b1, 8'h04, 32'h000C_045A);
    wb(1'b1, 8'h00, 32'h0000_001F);
    for (int k = 0; k < 2; k++) begin
      go();
      chk("dm addr", 32'h100 + 4 * k, xo.dm_addr);
      chk("pm addr", 32'h200 + k, {8'h0, xo.pm_addr});
    end
    wb(1'b1, 8'h08, 32'hDEAD_BEEF);
    wb(1'b1, 8'h00, 32'h0000_601F);
    go();
    chk("dm direct", 32'hDEAD_BEEF, xo.dm_addr);
    chk("pm direct", 32'h00AD_BEEF, {8'h0, xo.pm_addr});
    // index 2 stands at 0x108; pre-modify by data6 of -2, both writes
    wb(1'b1, 8'h00, 32'h0000_001F);
    wb(1'b1, 8'h04, 32'h01D7_E002);
    go();
    chk("dm imm6 modify", 32'h0000_0106, xo.dm_addr);
    chk("dm pm write", 32'h0000_0003, {xo.dm_wr, xo.pm_wr});
    wb(1'b1, 8'h08, 32'h1234_80FC);
    wb(1'b1, 8'h00, 32'h0000_011F);
    go();
    wb(1'b0, 8'h2C, 32'h0000_0000);
    chk("imm6 signed", 32'hFFFF_FFFC, q);
    wb(1'b1, 8'h00, 32'h0000_005F);
    go();
    wb(1'b0, 8'h2C, 32'h0000_0000);
    chk("imm16 unsigned", 32'h0000_80FC, q);
    $display("test transfers done");
    wb(1'b1, 8'h14, 32'h0000_0010);
    wb(1'b1, 8'h08, 32'h00FF_FFFC);
    wb(1'b1, 8'h00, 32'h0000_179F);
    go();
    chk("rel target", 32'h0000_000C, {8'h0, so.target});
    chk("pop count", 2, n_pop);
    wb(1'b1, 8'h08, 32'h0000_0123);
    wb(1'b1, 8'h00, 32'h0000_0A1F);
    go();
    chk("no early take", 1, n_tk);
    wb(1'b1, 8'h00, 32'h0000_001F);
    go();
    chk("slot one", 1, n_tk);
    go();
    chk("delayed take", 2, n_tk);
    chk("abs target", 32'h0000_0123, {8'h0, so.target});
    chk("pop unchanged", 2, n_pop);
    $display("test branches done");
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
